// [ssi_position_transmitter.sv]
/*
 * serial position transmitter: latches the position on the first falling
 * serial clock edge, shifts it out msb first on rising edges.
 * assumes the serial clock and strap pins are asynchronous and that
 * positions arrive from encoder logic on clk_i through a fifo.
 */
`timescale 1ns/1ps
module ssi_position_transmitter #(
  parameter int SINGLETURN_BITS  = ssi_pkg::SINGLETURN_BITS_DEF,
  parameter int MULTITURN_BITS   = ssi_pkg::MULTITURN_BITS_DEF,
  parameter int ZERO_HOLD_CYCLES = ssi_pkg::ZERO_HOLD_CYCLES
) (
  input  wire logic                  clk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  ce_i,
  input  wire ssi_pkg::pin_in_type   pins_i,
  input  wire logic                  pos_valid_i,
  input  wire ssi_pkg::position_type pos_data_i,
  output logic                       pos_ready_o,
  output logic                       data_o,
  output logic                       frame_active_o
);
  import ssi_pkg::*;

  localparam int WORD_BITS = SINGLETURN_BITS + MULTITURN_BITS;
  localparam position_type WORD_MASK = position_type'((40'h1 << WORD_BITS) - 40'h1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  pin_in_type      meta_ff;
  pin_in_type      nxt_meta;
  pin_in_type      sync_ff;
  pin_in_type      nxt_sync;
  pin_in_type      prev_ff;
  pin_in_type      nxt_prev;
  logic            sclk_fall;
  logic            sclk_rise;
  logic            sclk_edge;
  logic            zero_release;

  // two flops per pin, then one more for edge detection
  always_comb begin
    nxt_meta = pins_i;
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= PIN_RESET_VALUE;
      sync_ff <= PIN_RESET_VALUE;
      prev_ff <= PIN_RESET_VALUE;
    end else if (ce_i) begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  // edges of the sampled serial clock, 4 MHz leaves >30 cycles per half
  assign sclk_fall    = prev_ff.sclk & ~sync_ff.sclk;
  assign sclk_rise    = ~prev_ff.sclk & sync_ff.sclk;
  assign sclk_edge    = sclk_fall | sclk_rise;
  assign zero_release = prev_ff.zero_set & ~sync_ff.zero_set;

  ////////////////////////////////////////////////////////////////////////////
  // position input buffer
  frame_state_type state_ff;
  logic            fifo_valid;
  position_type    fifo_data;
  logic            fifo_pop;

  // positions are only taken while no frame runs
  assign fifo_pop = (state_ff == ST_IDLE);

  position_fifo #(
    .WIDTH (POS_MAX_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (pos_valid_i),
    .in_data_i   (pos_data_i),
    .in_ready_o  (pos_ready_o),
    .out_valid_o (fifo_valid),
    .out_data_o  (fifo_data),
    .out_ready_i (fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // position value: direction, zero offset, masking
  position_type           raw_ff;
  position_type           nxt_raw;
  position_type           offset_ff;
  position_type           nxt_offset;
  logic [ZERO_CNT_W-1:0]  zero_cnt_ff;
  logic [ZERO_CNT_W-1:0]  nxt_zero_cnt;
  position_type           negated;
  position_type           directed;
  position_type           out_pos;

  always_comb begin
    nxt_raw = (fifo_valid && fifo_pop) ? (fifo_data & WORD_MASK) : raw_ff;
    negated  = position_type'(~raw_ff + 1'b1);
    directed = sync_ff.direction ? negated : raw_ff;
    directed = directed & WORD_MASK;
    // lsb of the word is bit 0, msb at WORD_BITS-1, plain binary
    out_pos = position_type'(directed - offset_ff) & WORD_MASK;
    nxt_zero_cnt = zero_cnt_ff;
    nxt_offset   = offset_ff;
    if (sync_ff.zero_set) begin
      if (zero_cnt_ff < ZERO_CNT_W'(ZERO_HOLD_CYCLES)) begin
        nxt_zero_cnt = ZERO_CNT_W'(zero_cnt_ff + 1'b1);
      end
    end else begin
      nxt_zero_cnt = '0;
    end
    if (zero_release && zero_cnt_ff >= ZERO_CNT_W'(ZERO_HOLD_CYCLES)) begin
      nxt_offset = directed;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      raw_ff      <= '0;
      offset_ff   <= '0;
      zero_cnt_ff <= '0;
    end else if (ce_i) begin
      raw_ff      <= nxt_raw;
      offset_ff   <= nxt_offset;
      zero_cnt_ff <= nxt_zero_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame engine
  frame_state_type           nxt_state;
  position_type              shift_ff;
  position_type              nxt_shift;
  logic                      data_ff;
  logic                      nxt_data;
  logic [RECOVERY_CNT_W-1:0] rec_cnt_ff;
  logic [RECOVERY_CNT_W-1:0] nxt_rec_cnt;
  logic                      rec_done;

  // recovery expires after RECOVERY_CYCLES quiet system clocks
  assign rec_done = (rec_cnt_ff == RECOVERY_CNT_W'(RECOVERY_CYCLES - 1));

  always_comb begin
    nxt_state   = state_ff;
    nxt_shift   = shift_ff;
    nxt_data    = data_ff;
    nxt_rec_cnt = rec_cnt_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_data    = DATA_IDLE_LEVEL;
        nxt_rec_cnt = '0;
        // clock idles high, so a falling edge opens the frame
        if (sclk_fall) begin
          nxt_shift = out_pos;
          nxt_state = ST_FRAME;
        end
      end
      ST_FRAME: begin
        if (sclk_rise) begin
          // msb first, then one lower bit per rising edge, zeros refill
          nxt_data  = shift_ff[WORD_BITS-1];
          nxt_shift = shift_ff << 1;
        end
        if (sclk_edge) begin
          // retriggered recovery; edges here never re-latch
          nxt_rec_cnt = '0;
        end else if (rec_done) begin
          nxt_state = ST_IDLE;
          nxt_data  = DATA_IDLE_LEVEL;
        end else begin
          nxt_rec_cnt = RECOVERY_CNT_W'(rec_cnt_ff + 1'b1);
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_data  = DATA_IDLE_LEVEL;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff   <= ST_IDLE;
      shift_ff   <= '0;
      data_ff    <= DATA_IDLE_LEVEL;
      rec_cnt_ff <= '0;
    end else if (ce_i) begin
      state_ff   <= nxt_state;
      shift_ff   <= nxt_shift;
      data_ff    <= nxt_data;
      rec_cnt_ff <= nxt_rec_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign data_o         = data_ff;
  assign frame_active_o = (state_ff == ST_FRAME);
endmodule

// [ssi_pkg.sv]
/*
 * shared constants, types and timing counts for the serial position
 * transmitter and its input buffer.
 * assumes a 250 MHz system clock and a master-driven serial clock.
 */
package ssi_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // word layout
  localparam int POS_MAX_BITS        = 39;
  localparam int SINGLETURN_BITS_DEF = 23;
  localparam int MULTITURN_BITS_DEF  = 16;
  localparam int BIT_IDX_W           = 6;

  ////////////////////////////////////////////////////////////////////////////
  // buffering
  localparam int FIFO_DEPTH = 16;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_FREQ_MHZ        = 250;
  localparam int RECOVERY_TIME_NS    = 12000;
  localparam int RECOVERY_CYCLES     = RECOVERY_TIME_NS * CLK_FREQ_MHZ / 1000;
  localparam int RECOVERY_CNT_W      = 12;
  localparam int ZERO_HOLD_TIME_US   = 100;
  localparam int ZERO_HOLD_CYCLES    = ZERO_HOLD_TIME_US * CLK_FREQ_MHZ;
  localparam int ZERO_CNT_W          = 15;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic DATA_IDLE_LEVEL = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef logic [POS_MAX_BITS-1:0] position_type;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FRAME = 2'b01
  } frame_state_type;

  typedef struct packed {
    logic sclk;
    logic zero_set;
    logic direction;
  } pin_in_type;

  // synchroniser contents after reset, serial clock idle high
  localparam pin_in_type PIN_RESET_VALUE = '{sclk: 1'b1, zero_set: 1'b0, direction: 1'b0};

endpackage

// [position_fifo.sv]
/*
 * flip-flop fifo with valid/ready on both sides.
 * assumes one clock, clock enable freezing all state.
 */
`timescale 1ns/1ps
module position_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic      [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    nxt_wr_ptr;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW-1:0]    nxt_rd_ptr;
  logic [AW:0]      count_ff;
  logic [AW:0]      nxt_count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign out_data_o  = mem_ff[rd_ptr_ff];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_comb begin
    nxt_wr_ptr = push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
    nxt_rd_ptr = pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
    nxt_count  = count_ff;
    if (push && !pop) begin
      nxt_count = (AW+1)'(count_ff + 1'b1);
    end else if (pop && !push) begin
      nxt_count = (AW+1)'(count_ff - 1'b1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else if (ce_i) begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // storage entries
  for (genvar g = 0; g < DEPTH; g++) begin : g_entry
    logic [WIDTH-1:0] nxt_entry;
    always_comb begin
      nxt_entry = (push && wr_ptr_ff == AW'(g)) ? in_data_i : mem_ff[g];
    end
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        mem_ff[g] <= '0;
      end else if (ce_i) begin
        mem_ff[g] <= nxt_entry;
      end
    end
  end
endmodule

// [ssi_position_transmitter_props.sv]
/* checker on the transmitter ports.
   assumes sclk half periods far above the sync delay. */
`timescale 1ns/1ps
module ssi_position_transmitter_props
  import ssi_pkg::*;
(
  input wire logic                  clk_i,
  input wire logic                  rst_n_i,
  input wire logic                  ce_i,
  input wire ssi_pkg::pin_in_type   pins_i,
  input wire logic                  pos_valid_i,
  input wire ssi_pkg::position_type pos_data_i,
  input wire logic                  pos_ready_o,
  input wire logic                  data_o,
  input wire logic                  frame_active_o
);
  // recovery window around the package count, sync latency included
  localparam int REC_LO   = RECOVERY_CYCLES - 5;
  localparam int REC_HI   = RECOVERY_CYCLES + 10;
  localparam int REC_BUSY = RECOVERY_CYCLES - 10;

  logic [11:0] quiet_ff, nxt_quiet;
  logic        sclk_ff;
  // cycles since the sampled sclk last moved
  always_comb begin
    nxt_quiet = (quiet_ff == 12'hFFF) ? quiet_ff : quiet_ff + 12'h001;
    if (pins_i.sclk != sclk_ff) nxt_quiet = 12'h000;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      quiet_ff <= 12'h000;
      sclk_ff  <= 1'b1;
    end else if (ce_i) begin
      quiet_ff <= nxt_quiet;
      sclk_ff  <= pins_i.sclk;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_fall_idle; $fell(pins_i.sclk) && !frame_active_o; endsequence
  sequence s_frame_on; ##[1:4] frame_active_o; endsequence
  property p_latch_start; s_fall_idle |-> s_frame_on; endproperty
  a_latch_start: assert property (p_latch_start) else $error("no frame after falling sclk");
  property p_idle_high; !frame_active_o |-> data_o; endproperty
  a_idle_high: assert property (p_idle_high) else $error("data low while idle");
  property p_msb_wait; $rose(frame_active_o) |-> data_o; endproperty
  a_msb_wait: assert property (p_msb_wait) else $error("data moved at latch");
  property p_shift_on_rise; frame_active_o && $changed(data_o) |-> pins_i.sclk; endproperty
  a_shift_on_rise: assert property (p_shift_on_rise) else $error("data moved with sclk low");
  property p_rec_min;
    $fell(frame_active_o) |-> quiet_ff >= 12'(REC_LO) && quiet_ff <= 12'(REC_HI);
  endproperty
  a_rec_min: assert property (p_rec_min) else $error("recovery length wrong");
  property p_rec_max; quiet_ff > 12'(REC_HI) |-> !frame_active_o; endproperty
  a_rec_max: assert property (p_rec_max) else $error("frame outlived recovery");
  property p_stay_busy; frame_active_o && quiet_ff < 12'(REC_BUSY) |=> frame_active_o; endproperty
  a_stay_busy: assert property (p_stay_busy) else $error("frame ended early");
  property p_ready_fill; $fell(pos_ready_o) |-> $past(pos_valid_i); endproperty
  a_ready_fill: assert property (p_ready_fill) else $error("ready fell without a write");
endmodule

bind ssi_position_transmitter ssi_position_transmitter_props u_props (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .ce_i(ce_i), .pins_i(pins_i), .pos_valid_i(pos_valid_i), .pos_data_i(pos_data_i),
  .pos_ready_o(pos_ready_o), .data_o(data_o), .frame_active_o(frame_active_o));

// [ssi_master_model.sv]
/* behavioural master: clocks a burst, collects one bit per rise.
   assumes the bench pulses start_i only after done_o. */
`timescale 1ns/1ps
module ssi_master_model (
  input  wire logic        start_i,
  input  wire logic [6:0]  nclk_i,
  input  wire logic        data_i,
  output logic             sclk_o,
  output logic             done_o,
  output logic [63:0]      rx_o
);
  initial begin
    sclk_o = 1'b1;
    done_o = 1'b0;
    rx_o   = '0;
  end
  always @(posedge start_i) begin
    rx_o = '0;
    // keeps every sclk change off the system clock edges
    #1.25;
    for (int k = 0; k < nclk_i; k++) begin
      sclk_o = 1'b0;
      #62.5 sclk_o = 1'b1;
      #62.5 rx_o = {rx_o[62:0], data_i};
    end
    #20100 done_o = 1'b1;
    #12 done_o = 1'b0;
  end
endmodule

// [ssi_position_transmitter_bench.sv]
/* self-checking bench for the transmitter.
   assumes default word length and a shortened zero hold. */
`timescale 1ns/1ps
module ssi_position_transmitter_bench;
  import ssi_pkg::*;
  localparam int WORD = SINGLETURN_BITS_DEF + MULTITURN_BITS_DEF;
  logic         clk_i = 1'b0, rst_n_i = 1'b0, ce_i = 1'b1, pos_valid_i = 1'b0;
  logic         zero_set = 1'b0, direction = 1'b0, start = 1'b0;
  logic [6:0]   nclk = 7'h27;
  position_type pos_data_i = '0, base, off = '0, last;
  logic         pos_ready_o, data_o, frame_active_o, sclk, done;
  logic [63:0]  rx, exp_q[$];
  int           fails = 0, comparisons = 0, cnt, ncl[3] = '{WORD, WORD + 1, WORD + 4};
  pin_in_type   pins;
  assign pins = '{sclk: sclk, zero_set: zero_set, direction: direction};
  always #2 clk_i = ~clk_i;
  ssi_position_transmitter #(.ZERO_HOLD_CYCLES(20)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .pins_i(pins), .pos_valid_i(pos_valid_i), .pos_data_i(pos_data_i), .pos_ready_o(pos_ready_o),
    .data_o(data_o), .frame_active_o(frame_active_o));
  ssi_master_model u_master (.start_i(start), .nclk_i(nclk), .data_i(data_o), .sclk_o(sclk), .done_o(done),
    .rx_o(rx));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic position_type exp_of(input position_type v);
    return (direction ? position_type'(-v) : v) - off;
  endfunction
  task automatic push(input position_type v);
    pos_data_i <= v;
    pos_valid_i <= 1'b1;
    @(posedge clk_i);
    pos_valid_i <= 1'b0;
    repeat (5) @(posedge clk_i);
  endtask
  task automatic go(input int n, input position_type e);
    exp_q.push_back(64'(e) << (n - WORD));
    nclk <= 7'(n);
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
  endtask
  task automatic finish_frame;
    for (int w = 0; w < 10000 && !done; w++) @(posedge clk_i);
    if (done !== 1'b1) fails++;
    repeat (4) @(posedge clk_i);
    check("idle data", 64'(data_o), 64'h1);
    check("idle state", 64'(frame_active_o), 64'h0);
  endtask
  // monitor: each finished burst against the oldest note
  always @(posedge done) begin
    if (exp_q.size() > 0) check("frame", rx, exp_q.pop_front());
  end
  initial begin
    #250000;
    fails++;
    report_and_stop;
  end
  initial begin
    void'($urandom(72));
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    foreach (ncl[i]) begin
      base = position_type'({$urandom, $urandom});
      push(base);
      go(ncl[i], exp_of(base));
      finish_frame;
    end
    // clock enable low: an offered position must not be taken
    ce_i <= 1'b0;
    push(position_type'({$urandom, $urandom}));
    ce_i <= 1'b1;
    go(WORD, exp_of(base));
    finish_frame;
    direction <= 1'b1;
    base = position_type'({$urandom, $urandom});
    push(base);
    go(WORD + 1, exp_of(base));
    finish_frame;
    direction <= 1'b0;
    base = position_type'({$urandom, $urandom});
    push(base);
    zero_set <= 1'b1;
    repeat (25) @(posedge clk_i);
    zero_set <= 1'b0;
    repeat (6) @(posedge clk_i);
    off = base;
    last = position_type'({$urandom, $urandom});
    push(last);
    go(WORD, exp_of(last));
    repeat (30) @(posedge clk_i);
    cnt = 0;
    pos_valid_i <= 1'b1;
    for (int k = 0; k < 20; k++) begin
      pos_data_i <= position_type'({$urandom, $urandom});
      #1;
      if (pos_ready_o === 1'b1) begin
        cnt++;
        last = pos_data_i;
      end
      @(posedge clk_i);
    end
    pos_valid_i <= 1'b0;
    check("fifo fill", 64'(cnt), 64'(FIFO_DEPTH));
    finish_frame;
    repeat (40) @(posedge clk_i);
    go(WORD, exp_of(last));
    finish_frame;
    check("pending", 64'(exp_q.size()), 64'h0);
    report_and_stop;
  end
endmodule
